/* logic/mal_pkg.sv */
// constants, taskfile carrier types and helpers for the max address limit command block
package mal_pkg;

    //------------------------------------------------------------
    // widths
    //------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int LBA_W  = 48;

    //------------------------------------------------------------
    // register byte offsets on the avalon slave
    //------------------------------------------------------------
    localparam logic [5:0] OFS_FEATURE  = 6'h00;
    localparam logic [5:0] OFS_SECCNT   = 6'h04;
    localparam logic [5:0] OFS_LBA_LO   = 6'h08;
    localparam logic [5:0] OFS_LBA_MID  = 6'h0c;
    localparam logic [5:0] OFS_LBA_HI   = 6'h10;
    localparam logic [5:0] OFS_LBA_PREV = 6'h14;
    localparam logic [5:0] OFS_DEVICE   = 6'h18;
    localparam logic [5:0] OFS_COMMAND  = 6'h1c;
    localparam logic [5:0] OFS_CONTROL  = 6'h20;
    localparam logic [5:0] OFS_STATUS   = 6'h24;
    localparam logic [5:0] OFS_ID_W60   = 6'h28;
    localparam logic [5:0] OFS_ID_W100L = 6'h2c;
    localparam logic [5:0] OFS_ID_W100H = 6'h30;
    localparam logic [5:0] OFS_MAX_LO   = 6'h34;
    localparam logic [5:0] OFS_MAX_HI   = 6'h38;
    localparam logic [5:0] OFS_LOCKS    = 6'h3c;

    //------------------------------------------------------------
    // opcodes, security subcommand codes, field positions
    //------------------------------------------------------------
    localparam logic [7:0] OP_SET_MAX     = 8'hf9;
    localparam logic [7:0] OP_SET_MAX_EXT = 8'h37;
    localparam logic [7:0] SUB_SET_PW     = 8'h01;
    localparam logic [7:0] SUB_LOCK       = 8'h02;
    localparam logic [7:0] SUB_UNLOCK     = 8'h03;
    localparam logic [7:0] SUB_FREEZE     = 8'h04;
    localparam int SC_PERSIST_BIT = 0;
    localparam int DEV_LBA_BIT    = 6;
    localparam int CTL_UPPER_SEL_BIT = 7;
    localparam int ST_BSY_BIT     = 7;
    localparam int ST_RDY_BIT     = 6;
    localparam int ST_ERR_BIT     = 0;
    localparam int ER_ABORT_BIT   = 2;

    //------------------------------------------------------------
    // address ceilings and chs geometry reported back
    //------------------------------------------------------------
    localparam logic [47:0] LBA28_MAX     = 48'h0000_0fff_ffff;
    localparam logic [7:0]  CHS_SECTORS   = 8'h3f;
    localparam logic [3:0]  CHS_MAX_HEAD  = 4'hf;
    localparam logic [47:0] CHS_TRACK_LEN = 48'h0000_0000_03f0;

    //------------------------------------------------------------
    // carriers
    //------------------------------------------------------------
    typedef struct packed {
        logic [7:0] feature;
        logic [7:0] seccnt;
        logic [7:0] lba_lo;
        logic [7:0] lba_mid;
        logic [7:0] lba_hi;
        logic [7:0] prev_lo;
        logic [7:0] prev_mid;
        logic [7:0] prev_hi;
        logic [7:0] device;
    } mal_taskfile_type;

    typedef struct packed {
        logic [47:0] w100;
        logic [27:0] w60;
    } mal_ident_type;

    // 48-bit address from both byte layers
    function automatic logic [47:0] mal_lba48(input mal_taskfile_type t);
        return {t.prev_hi, t.prev_mid, t.prev_lo, t.lba_hi, t.lba_mid, t.lba_lo};
    endfunction : mal_lba48

    // 28-bit address from head nibble and three bytes, zero extended
    function automatic logic [47:0] mal_lba28(input mal_taskfile_type t);
        return {20'h00000, t.device[3:0], t.lba_hi, t.lba_mid, t.lba_lo};
    endfunction : mal_lba28

endpackage : mal_pkg

/* logic/mal_limit_cmd.sv */
// max address limit command interpreter with avalon-mm taskfile access
//------------------------------------------------------------
// Functional notes
// - security form of F9h: feature 01h password, 02h lock, 03h unlock, 04h freeze.
// - address-limit form of F9h ignores the feature value.
// - F9h sector count bit 0: 1 keeps limit across power-on, 0 loses it.
// - lba limit: low 7:0, mid 15:8, high 23:16, head nibble 27:24.
// - chs limit: cylinder from high and mid; low and head nibble ignored.
// - lba completion returns adjusted limit in low, mid, high and head nibble.
// - chs completion returns cylinder, 63 in low, 15 as head.
// - 37h accepted only right after the extended native maximum read.
// - after a limit is set, accesses above it abort.
// - extended limit above 28-bit ceiling updates words 103:100 only.
// - extended limit at or below ceiling updates words 103:100 and 61:60.
// - 37h aborts: unsupported, over capacity, set by F9h, not preceded, locked/frozen.
// - second persistent 37h aborts until next power-on.
// - 37h sector count bit 0: 1 persistent, 0 volatile.
// - readback shows lower bytes with upper select 0, upper bytes with 1.
// - F9h is a limit request only right after native max read, else security.
// - F9h aborts when locked, frozen, or limit was set by 37h.
//------------------------------------------------------------
`timescale 1ns/1ps

module mal_limit_cmd #(
    parameter logic [47:0] NATIVE_MAX          = 48'h0000_2540_be40,
    parameter logic [7:0]  CMD_READ_NATIVE     = 8'hf8,
    parameter logic [7:0]  CMD_READ_NATIVE_EXT = 8'h27,
    parameter bit          EXT_SUPPORTED       = 1'b1
) (
    input  wire logic                         clock,
    input  wire logic                         srst,
    input  wire logic [mal_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                         avs_read,
    input  wire logic                         avs_write,
    input  wire logic [mal_pkg::DATA_W-1:0]   avs_writedata,
    output logic      [mal_pkg::DATA_W-1:0]   avs_readdata,
    output logic                              avs_waitrequest,
    input  wire logic [mal_pkg::LBA_W-1:0]    nv_limit_in,
    output logic      [mal_pkg::LBA_W-1:0]    nv_limit_out,
    output logic                              nv_limit_write
);
    import mal_pkg::*;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_EXEC = 2'b10
    } mal_state_type;
    mal_state_type      state_q;
    mal_taskfile_type   tf_q;
    mal_ident_type      ident_q;
    logic [7:0]         cmd_q;
    logic               upper_byte_readback_select_q;
    logic               abort_flag_q;
    logic [47:0]        max_q;
    logic               locked_q;
    logic               frozen_q;
    logic               prev_native_q;
    logic               prev_native_ext_q;
    logic               set_by_28_q;
    logic               set_by_ext_q;
    logic               nv_ext_done_q;
    logic [31:0]        readdata_q;
    logic               waitrequest_q;
    logic [47:0]        nv_limit_q;
    logic               nv_write_q;
    logic               wr_go;
    logic               rd_go;
    logic [47:0]        req48;
    logic [47:0]        req28;
    logic [47:0]        chs_limit;
    logic [47:0]        limit28;
    logic               is_lba;
    logic               persist;
    logic               set28_go;
    logic               sec_go;
    logic               ext_go;
    logic               native_go;
    logic               abort_d;
    logic [7:0]         status_byte;
    logic [47:0]        boot_max;
    logic [23:0]        lba_view;
    assign avs_readdata    = readdata_q;
    assign avs_waitrequest = waitrequest_q;
    assign nv_limit_out    = nv_limit_q;
    assign nv_limit_write  = nv_write_q;
    //------------------------------------------------------------
    // avalon slave handshake
    //------------------------------------------------------------
    // one wait cycle per access; writes commit on the edge with waitrequest low, reads are captured on the wait edge
    always_ff @(posedge clock) begin
        if (srst) begin
            waitrequest_q <= 1'b1;
        end else if ((avs_read || avs_write) && waitrequest_q) begin
            waitrequest_q <= 1'b0;
        end else begin
            waitrequest_q <= 1'b1;
        end
    end
    assign wr_go = avs_write && !waitrequest_q;
    assign rd_go = avs_read && waitrequest_q;
    assign lba_view = upper_byte_readback_select_q ? {tf_q.prev_hi, tf_q.prev_mid, tf_q.prev_lo}
                                                   : {tf_q.lba_hi, tf_q.lba_mid, tf_q.lba_lo};
    // status byte: busy while executing, abort shown through err
    always_comb begin
        status_byte              = 8'h00;
        status_byte[ST_BSY_BIT]  = (state_q == ST_EXEC);
        status_byte[ST_RDY_BIT]  = (state_q == ST_IDLE);
        status_byte[ST_ERR_BIT]  = abort_flag_q;
    end
    // read mux, captured with the wait cycle; unmapped offsets read zero
    always_ff @(posedge clock) begin
        if (srst) begin
            readdata_q <= 32'h0000_0000;
        end else if (rd_go) begin
            case (avs_address)
                OFS_FEATURE:  readdata_q <= {24'h000000, tf_q.feature};
                OFS_SECCNT:   readdata_q <= {24'h000000, tf_q.seccnt};
                OFS_LBA_LO:   readdata_q <= {24'h000000, lba_view[7:0]};
                OFS_LBA_MID:  readdata_q <= {24'h000000, lba_view[15:8]};
                OFS_LBA_HI:   readdata_q <= {24'h000000, lba_view[23:16]};
                OFS_LBA_PREV: readdata_q <= {8'h00, tf_q.prev_hi, tf_q.prev_mid, tf_q.prev_lo};
                OFS_DEVICE:   readdata_q <= {24'h000000, tf_q.device};
                OFS_COMMAND:  readdata_q <= {24'h000000, cmd_q};
                OFS_CONTROL:  readdata_q <= {24'h000000, upper_byte_readback_select_q, 7'h00};
                OFS_STATUS:   readdata_q <= {16'h0000, 5'h00, abort_flag_q, 2'h0, status_byte};
                OFS_ID_W60:   readdata_q <= {4'h0, ident_q.w60};
                OFS_ID_W100L: readdata_q <= ident_q.w100[31:0];
                OFS_ID_W100H: readdata_q <= {16'h0000, ident_q.w100[47:32]};
                OFS_MAX_LO:   readdata_q <= max_q[31:0];
                OFS_MAX_HI:   readdata_q <= {16'h0000, max_q[47:32]};
                OFS_LOCKS:    readdata_q <= {26'h0000000, set_by_ext_q, set_by_28_q, nv_ext_done_q,
                                             prev_native_ext_q, frozen_q, locked_q};
                default:      readdata_q <= 32'h0000_0000;
            endcase
        end
    end

    //------------------------------------------------------------
    // command decode and abort conditions
    //------------------------------------------------------------
    always_comb begin
        req48     = mal_lba48(tf_q);
        req28     = mal_lba28(tf_q);
        chs_limit = ({32'h0000_0000, tf_q.lba_hi, tf_q.lba_mid} + 48'h1) * CHS_TRACK_LEN - 48'h1;
        is_lba    = tf_q.device[DEV_LBA_BIT];
        limit28   = is_lba ? req28 : chs_limit;
        persist   = tf_q.seccnt[SC_PERSIST_BIT];
        set28_go  = (cmd_q == OP_SET_MAX) && prev_native_q;
        sec_go    = (cmd_q == OP_SET_MAX) && !prev_native_q;
        ext_go    = (cmd_q == OP_SET_MAX_EXT);
        native_go = (cmd_q == CMD_READ_NATIVE) || (cmd_q == CMD_READ_NATIVE_EXT);
        abort_d   = 1'b0;
        if (set28_go) begin
            // feature value plays no part here
            abort_d = locked_q || frozen_q || set_by_ext_q || (limit28 > NATIVE_MAX);
        end else if (sec_go) begin
            case (tf_q.feature)
                SUB_SET_PW: abort_d = locked_q || frozen_q;
                SUB_LOCK:   abort_d = frozen_q;
                SUB_UNLOCK: abort_d = frozen_q;
                SUB_FREEZE: abort_d = 1'b0;
                default:    abort_d = 1'b1;
            endcase
        end else if (ext_go) begin
            abort_d = !EXT_SUPPORTED || (req48 > NATIVE_MAX) || set_by_28_q
                      || !prev_native_ext_q || locked_q || frozen_q
                      || (persist && nv_ext_done_q);
        end else if (!native_go) begin
            // any other command is a media access checked against the limit
            abort_d = req48 > max_q;
        end
    end

    //------------------------------------------------------------
    // command sequencer
    //------------------------------------------------------------
    // a command write while busy is dropped; the host must poll for ready
    always_ff @(posedge clock) begin
        if (srst) begin
            state_q <= ST_IDLE;
            cmd_q   <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (wr_go && avs_address == OFS_COMMAND) begin
                        cmd_q   <= avs_writedata[7:0];
                        state_q <= ST_EXEC;
                    end
                end
                ST_EXEC: state_q <= ST_IDLE;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // abort flag reflects the outcome of the last command
    always_ff @(posedge clock) begin
        if (srst) begin
            abort_flag_q <= 1'b0;
        end else if (state_q == ST_EXEC) begin
            abort_flag_q <= abort_d;
        end
    end

    // upper byte readback select, host control register
    always_ff @(posedge clock) begin
        if (srst) begin
            upper_byte_readback_select_q <= 1'b0;
        end else if (wr_go && avs_address == OFS_CONTROL) begin
            upper_byte_readback_select_q <= avs_writedata[CTL_UPPER_SEL_BIT];
        end
    end

    //------------------------------------------------------------
    // taskfile: host writes when idle, device writes results
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            tf_q <= '0;
        end else if (state_q == ST_IDLE && wr_go) begin
            case (avs_address)
                OFS_FEATURE:  tf_q.feature <= avs_writedata[7:0];
                OFS_SECCNT:   tf_q.seccnt  <= avs_writedata[7:0];
                OFS_LBA_LO:   tf_q.lba_lo  <= avs_writedata[7:0];
                OFS_LBA_MID:  tf_q.lba_mid <= avs_writedata[7:0];
                OFS_LBA_HI:   tf_q.lba_hi  <= avs_writedata[7:0];
                OFS_LBA_PREV: begin
                    tf_q.prev_lo  <= avs_writedata[7:0];
                    tf_q.prev_mid <= avs_writedata[15:8];
                    tf_q.prev_hi  <= avs_writedata[23:16];
                end
                OFS_DEVICE:   tf_q.device  <= avs_writedata[7:0];
                default:      tf_q.feature <= tf_q.feature;
            endcase
        end else if (state_q == ST_EXEC && !abort_d) begin
            if (set28_go && is_lba) begin
                tf_q.lba_lo      <= limit28[7:0];
                tf_q.lba_mid     <= limit28[15:8];
                tf_q.lba_hi      <= limit28[23:16];
                tf_q.device[3:0] <= limit28[27:24];
            end else if (set28_go) begin
                tf_q.lba_lo      <= CHS_SECTORS;
                tf_q.device[3:0] <= CHS_MAX_HEAD;
            end else if (native_go) begin
                {tf_q.prev_hi, tf_q.prev_mid, tf_q.prev_lo} <= NATIVE_MAX[47:24];
                {tf_q.lba_hi, tf_q.lba_mid, tf_q.lba_lo}    <= NATIVE_MAX[23:0];
                tf_q.device[3:0] <= NATIVE_MAX[27:24];
            end
        end
    end

    //------------------------------------------------------------
    // limit, identify words and persistent store
    //------------------------------------------------------------
    // reset stands for power-on: volatile limits fall back to the stored one
    assign boot_max = (nv_limit_in == 48'h0 || nv_limit_in > NATIVE_MAX) ? NATIVE_MAX : nv_limit_in;

    always_ff @(posedge clock) begin
        if (srst) begin
            max_q        <= boot_max;
            ident_q.w100 <= boot_max;
            ident_q.w60  <= (boot_max > LBA28_MAX) ? LBA28_MAX[27:0] : boot_max[27:0];
        end else if (state_q == ST_EXEC && !abort_d && set28_go) begin
            max_q        <= limit28;
            ident_q.w60  <= limit28[27:0];
            // a request at the 28-bit ceiling reports the whole native range in words 103:100; max_q keeps the ceiling
            ident_q.w100 <= (limit28 == LBA28_MAX) ? NATIVE_MAX : limit28;
        end else if (state_q == ST_EXEC && !abort_d && ext_go) begin
            max_q        <= req48;
            ident_q.w100 <= req48;
            if (req48 <= LBA28_MAX) begin
                ident_q.w60 <= req48[27:0];
            end
        end
    end
    // persistent copy handed to the nonvolatile store
    always_ff @(posedge clock) begin
        if (srst) begin
            nv_limit_q <= 48'h0;
            nv_write_q <= 1'b0;
        end else begin
            nv_write_q <= state_q == ST_EXEC && !abort_d && persist && (set28_go || ext_go);
            if (state_q == ST_EXEC && !abort_d && persist && set28_go) begin
                nv_limit_q <= limit28;
            end else if (state_q == ST_EXEC && !abort_d && persist && ext_go) begin
                nv_limit_q <= req48;
            end
        end
    end

    //------------------------------------------------------------
    // state kept between commands
    //------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            prev_native_q     <= 1'b0;
            prev_native_ext_q <= 1'b0;
            set_by_28_q       <= 1'b0;
            set_by_ext_q      <= 1'b0;
            nv_ext_done_q     <= 1'b0;
        end else if (state_q == ST_EXEC) begin
            // only the command right before counts
            prev_native_q     <= cmd_q == CMD_READ_NATIVE && !abort_d;
            prev_native_ext_q <= cmd_q == CMD_READ_NATIVE_EXT && !abort_d;
            if (!abort_d && set28_go) begin
                set_by_28_q <= 1'b1;
            end
            if (!abort_d && ext_go) begin
                set_by_ext_q <= 1'b1;
            end
            if (!abort_d && ext_go && persist) begin
                nv_ext_done_q <= 1'b1;
            end
        end
    end
    // security lock state driven by the subcommand form
    always_ff @(posedge clock) begin
        if (srst) begin
            locked_q <= 1'b0;
            frozen_q <= 1'b0;
        end else if (state_q == ST_EXEC && sec_go && !abort_d) begin
            if (tf_q.feature == SUB_LOCK) begin
                locked_q <= 1'b1;
            end else if (tf_q.feature == SUB_UNLOCK) begin
                locked_q <= 1'b0;
            end else if (tf_q.feature == SUB_FREEZE) begin
                frozen_q <= 1'b1;
            end
        end
    end

    //------------------------------------------------------------
    // checks
    //------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    sequence s_exec_ext;
        state_q == ST_EXEC && cmd_q == OP_SET_MAX_EXT;
    endsequence
    sequence s_exec_set28;
        state_q == ST_EXEC && cmd_q == OP_SET_MAX && prev_native_q;
    endsequence
    a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest did not drop after one cycle");
    a_ext_order: assert property (s_exec_ext ##0 !prev_native_ext_q |=> abort_flag_q && $stable(max_q))
        else $error("extended set not aborted without preceding native read");
    a_ext_persist_once: assert property (s_exec_ext ##0 (persist && nv_ext_done_q) |=> abort_flag_q)
        else $error("second persistent extended set not aborted");
    a_set28_locked: assert property (s_exec_set28 ##0 (locked_q || frozen_q) |=> abort_flag_q)
        else $error("limit set accepted while locked or frozen");
    a_ident_high: assert property (s_exec_ext ##0 (!abort_d && req48 > LBA28_MAX)
                                   |=> $stable(ident_q.w60) && ident_q.w100 == $past(req48))
        else $error("identify words wrong for large limit");
    a_ident_low: assert property (s_exec_ext ##0 (!abort_d && req48 <= LBA28_MAX)
                                  |=> ident_q.w60 == $past(req48[27:0]) && max_q == $past(req48))
        else $error("identify words wrong for small limit");
    a_chs_result: assert property (s_exec_set28 ##0 (!abort_d && !is_lba)
                                   |=> tf_q.lba_lo == CHS_SECTORS && tf_q.device[3:0] == CHS_MAX_HEAD)
        else $error("chs completion values wrong");
    a_lba_result: assert property (s_exec_set28 ##0 (!abort_d && is_lba)
                                   |=> mal_lba28(tf_q) == max_q ##1 state_q == ST_IDLE)
        else $error("lba completion does not echo limit");
    a_access_reject: assert property (state_q == ST_EXEC && !native_go && cmd_q != OP_SET_MAX
                                      && !ext_go && req48 > max_q |=> abort_flag_q)
        else $error("access above limit not aborted");
    a_upper_readback: assert property (rd_go && avs_address == OFS_LBA_LO && upper_byte_readback_select_q
                                       |=> avs_readdata[7:0] == tf_q.prev_lo)
        else $error("upper byte readback wrong");

endmodule : mal_limit_cmd

/* verif/mal_nv_store.sv */
// nonvolatile limit store standing beside the limit block
`timescale 1ns/1ps
module mal_nv_store (
    input  wire logic        clock,
    input  wire logic [47:0] nv_limit_out,
    input  wire logic        nv_limit_write,
    output logic      [47:0] nv_limit_in
);
    // empty store at power-up, so the first reset brings back the native size
    initial nv_limit_in = 48'h0;
    always @(posedge clock) begin
        if (nv_limit_write === 1'b1) nv_limit_in <= nv_limit_out;
    end
endmodule : mal_nv_store

/* verif/mal_limit_cmd_bench.sv */
// self-checking bench for the max address limit command block
`timescale 1ns/1ps
module mal_limit_cmd_bench;
    import mal_pkg::*;
    localparam logic [47:0] NAT = 48'h0000_2540_be40;
    logic        clock, srst, avs_read, avs_write, avs_waitrequest, nv_limit_write;
    logic [5:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [47:0] nv_limit_in, nv_limit_out;
    logic [7:0]  sf [4] = '{SUB_LOCK, SUB_UNLOCK, SUB_SET_PW, SUB_FREEZE};
    logic [31:0] se [4] = '{32'h1, 32'h0, 32'h0, 32'h2};
    int          err_total, tests_run;
    logic        lmode = 1'b1;
    mal_limit_cmd #(.NATIVE_MAX(NAT)) dut (.clock(clock), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .nv_limit_in(nv_limit_in),
        .nv_limit_out(nv_limit_out), .nv_limit_write(nv_limit_write));
    mal_nv_store nv (.clock(clock), .nv_limit_out(nv_limit_out), .nv_limit_write(nv_limit_write),
        .nv_limit_in(nv_limit_in));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // one avalon access; request held until waitrequest is seen low
    task automatic acc(input logic [5:0] a, input logic w, input logic [31:0] d);
        avs_address <= a; avs_write <= w; avs_read <= ~w; avs_writedata <= d;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0) @(posedge clock);
        q = avs_readdata;
        avs_read <= 1'b0; avs_write <= 1'b0;
        @(posedge clock);
    endtask : acc
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            err_total++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic rc(input logic [5:0] a, input string n, input logic [31:0] e);
        acc(a, 1'b0, 32'h0);
        chk(n, q, e);
    endtask : rc
    task automatic ab(input logic e);
        acc(OFS_STATUS, 1'b0, 32'h0);
        chk("abort", {31'h0, q[10]}, {31'h0, e});
    endtask : ab
    // whole taskfile then the opcode; mode bit from lmode, head nibble from bits 27:24
    task automatic cmd(input logic [7:0] op, input logic [7:0] f, input logic [7:0] sc, input logic [47:0] l);
        acc(OFS_FEATURE, 1'b1, {24'h0, f}); acc(OFS_SECCNT, 1'b1, {24'h0, sc});
        acc(OFS_LBA_LO, 1'b1, {24'h0, l[7:0]}); acc(OFS_LBA_MID, 1'b1, {24'h0, l[15:8]});
        acc(OFS_LBA_HI, 1'b1, {24'h0, l[23:16]}); acc(OFS_LBA_PREV, 1'b1, {8'h0, l[47:24]});
        acc(OFS_DEVICE, 1'b1, {24'h0, 1'b0, lmode, 2'b00, l[27:24]}); acc(OFS_COMMAND, 1'b1, {24'h0, op});
    endtask : cmd
    task automatic rst;
        srst <= 1'b1;
        repeat (16) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
    endtask : rst
    task automatic print_verdict;
        if (err_total == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    // watchdog: 20000 cycles, far above the few hundred the whole sequence takes
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        print_verdict();
    end
    initial begin
        srst = 1'b1; avs_read = 1'b0; avs_write = 1'b0; avs_address = 6'h00; avs_writedata = 32'h0;
        err_total = 0; tests_run = 0;
        rst();
        // chs form: cylinder 1 in mid and high, low byte and head nibble must be ignored
        cmd(8'hf8, 8'h00, 8'h00, 48'h0); lmode = 1'b0;
        cmd(OP_SET_MAX, 8'h00, 8'h00, 48'h03000177); lmode = 1'b1;
        rc(OFS_MAX_LO, "chs max", 32'h000007df);
        rc(OFS_LBA_LO, "chs sectors", 32'h0000003f);
        rc(OFS_LBA_MID, "chs cylinder", 32'h00000001);
        rc(OFS_DEVICE, "chs head", 32'h0000000f);
        cmd(8'hf8, 8'h00, 8'h00, 48'h0); cmd(OP_SET_MAX, 8'h55, 8'h00, 48'h1123456);
        ab(1'b0);
        rc(OFS_MAX_LO, "max lo", 32'h01123456);
        rc(OFS_LBA_LO, "lba lo", 32'h00000056);
        cmd(8'h27, 8'h00, 8'h00, 48'h0); cmd(OP_SET_MAX_EXT, 8'h00, 8'h00, 48'h100);
        ab(1'b1);
        rst();
        rc(OFS_MAX_LO, "max lo", NAT[31:0]);
        cmd(OP_SET_MAX_EXT, 8'h00, 8'h01, 48'h100);
        ab(1'b1);
        cmd(8'h27, 8'h00, 8'h00, 48'h0); cmd(OP_SET_MAX_EXT, 8'h00, 8'h00, 48'h200000);
        ab(1'b0);
        rc(OFS_ID_W60, "w60 small", 32'h00200000);
        rc(OFS_ID_W100L, "w100 small", 32'h00200000);
        cmd(8'h27, 8'h00, 8'h00, 48'h0); cmd(OP_SET_MAX_EXT, 8'h00, 8'h01, 48'h12000000);
        ab(1'b0);
        chk("nv out", nv_limit_out[31:0], 32'h12000000);
        rc(OFS_ID_W100L, "w100", 32'h12000000);
        rc(OFS_ID_W60, "w60", 32'h00200000);
        acc(OFS_CONTROL, 1'b1, 32'h80);
        rc(OFS_LBA_LO, "lba lo upper", 32'h00000012);
        cmd(8'h27, 8'h00, 8'h00, 48'h0); cmd(OP_SET_MAX_EXT, 8'h00, 8'h01, 48'h11000000);
        ab(1'b1);
        rst();
        rc(OFS_MAX_LO, "max lo", 32'h12000000);
        cmd(8'h25, 8'h00, 8'h00, 48'h13000000);
        ab(1'b1);
        // security forms: no native read before, so the feature value picks the action
        for (int i = 0; i < 4; i++) begin
            cmd(OP_SET_MAX, sf[i], 8'h00, 48'h0);
            acc(OFS_LOCKS, 1'b0, 32'h0);
            chk("locks", {30'h0, q[1:0]}, se[i]);
        end
        cmd(8'hf8, 8'h00, 8'h00, 48'h0); cmd(OP_SET_MAX, 8'h00, 8'h00, 48'h100);
        ab(1'b1);
        print_verdict();
    end
endmodule : mal_limit_cmd_bench
